// file: src/adc_mode_control_registers.sv
// mode control register bank with its serial write/readback port
module adc_mode_control_registers
  import adc_mode_pkg::*;
(
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic sck,
  input wire logic cs_n,
  input wire logic serial_data_in,
  output logic serial_data_out,
  output logic serial_data_out_oe,
  input wire logic sample_tick,
  output logic software_reset_active,
  output logic [1:0] power_down_select,
  output logic channel1_napped,
  output logic channel2_napped,
  output logic full_sleep,
  output logic output_clock_invert,
  output logic [1:0] output_clock_phase_delay,
  output logic duty_cycle_stabilizer_on,
  output logic [2:0] differential_drive_current,
  output logic [9:0] drive_current_10ua,
  output logic internal_termination_on,
  output logic output_disable,
  output logic [1:0] output_format_select,
  output logic [2:0] test_pattern_select,
  output logic test_pattern_active,
  output logic overflow_flag,
  output logic [13:0] sample_bits,
  output logic alternate_polarity_on,
  output logic output_scrambler_on,
  output logic signed_format_select
);

  // ****************************************
  // functions
  // ****************************************
  function automatic logic [DATA_W-1:0] reg_mask(input logic [2:0] idx);
    case (idx)
      3'h1: reg_mask = MASK_POWER;
      3'h2: reg_mask = MASK_TIMING;
      3'h3: reg_mask = MASK_DRIVER;
      3'h4: reg_mask = MASK_FORMAT;
      default: reg_mask = 8'h00;
    endcase
  endfunction

  function automatic logic [9:0] cur_of(input logic [2:0] code);
    case (code)
      3'h0: cur_of = CUR_3P50;
      3'h1: cur_of = CUR_4P00;
      3'h2: cur_of = CUR_4P50;
      3'h4: cur_of = CUR_3P00;
      3'h5: cur_of = CUR_2P50;
      3'h6: cur_of = CUR_2P10;
      3'h7: cur_of = CUR_1P75;
      default: cur_of = CUR_UNUSED;
    endcase
  endfunction

  function automatic logic mapped(input logic [ADDR_W-1:0] a);
    mapped = (a >= ADDR_POWER) && (a <= ADDR_FORMAT);
  endfunction

  // ****************************************
  // link side: frame shift register
  // ****************************************
  logic frame_clr;
  logic [4:0] bit_cnt_r;
  logic [14:0] shift_r;
  logic [15:0] full_word;

  assign frame_clr = !resetn || cs_n;
  assign full_word = {shift_r, serial_data_in};

  always_ff @(posedge sck or posedge frame_clr)
  begin
    if (frame_clr)
    begin
      bit_cnt_r <= 5'h00;
      shift_r <= 15'h0000;
    end
    else if (bit_cnt_r < WORD_BITS) // [R23]
    begin
      shift_r <= full_word[14:0]; // [R22]
      bit_cnt_r <= bit_cnt_r + 5'h01;
    end
  end

  // ****************************************
  // link side: write capture
  // ****************************************
  logic [ADDR_W-1:0] wr_addr_r;
  logic [DATA_W-1:0] wr_data_r;
  logic wr_tgl_r;

  always_ff @(posedge sck or negedge resetn)
  begin
    if (!resetn)
    begin
      wr_addr_r <= 7'h00;
      wr_data_r <= 8'h00;
      wr_tgl_r <= 1'b0;
    end
    else if (!cs_n && bit_cnt_r == LAST_EDGE && !full_word[15]) // [R22]
    begin
      wr_addr_r <= full_word[14:8];
      wr_data_r <= full_word[7:0];
      wr_tgl_r <= !wr_tgl_r;
    end
  end

  // ****************************************
  // link side: copy of the bank for readback
  // ****************************************
  logic [2:0] pub_sync_r;
  logic pub_seen_r;
  logic [DATA_W-1:0] copy_r [1:4];
  logic [31:0] pub_r;
  logic pub_tgl_r;

  always_ff @(posedge sck or negedge resetn)
  begin
    if (!resetn)
    begin
      pub_sync_r <= 3'h0;
      pub_seen_r <= 1'b0;
      for (int i = 1; i <= 4; i++)
        copy_r[i] <= REG_RESET;
    end
    else
    begin
      pub_sync_r <= {pub_sync_r[1:0], pub_tgl_r};
      if (pub_sync_r[1] == pub_sync_r[2] && pub_sync_r[2] != pub_seen_r)
      begin
        pub_seen_r <= pub_sync_r[2];
        for (int i = 1; i <= 4; i++)
          copy_r[i] <= pub_r[8*i-1 -: 8];
      end
    end
  end

  // ****************************************
  // link side: readback on falling edges
  // ****************************************
  logic [DATA_W-1:0] rd_word;
  logic rd_act_r;
  logic [DATA_W-1:0] rd_shift_r;

  always_comb
  begin
    rd_word = 8'h00; // [R4] [R26]
    if (mapped(shift_r[6:0]))
      rd_word = copy_r[shift_r[2:0]];
  end

  always_ff @(negedge sck or posedge frame_clr)
  begin
    if (frame_clr)
    begin
      rd_act_r <= 1'b0;
      rd_shift_r <= 8'h00;
      serial_data_out_oe <= 1'b0;
    end
    else if (bit_cnt_r == ADDR_DONE)
    begin
      rd_act_r <= shift_r[7];
      rd_shift_r <= rd_word;
      serial_data_out_oe <= shift_r[7] && !rd_word[7]; // [R24]
    end
    else if (rd_act_r && bit_cnt_r < WORD_BITS)
    begin
      rd_shift_r <= {rd_shift_r[6:0], 1'b0};
      serial_data_out_oe <= !rd_shift_r[6]; // [R24]
    end
    else
      serial_data_out_oe <= 1'b0;
  end

  // open drain: only ever pulls low
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
      serial_data_out <= 1'b0;
    else
      serial_data_out <= 1'b0;
  end

  // ****************************************
  // system side: crossings from the link
  // ****************************************
  logic [2:0] wr_sync_r;
  logic wr_seen_r;
  logic [2:0] cs_sync_r;
  logic cs_high_r;
  logic wr_evt;

  assign wr_evt = (wr_sync_r[1] == wr_sync_r[2]) && (wr_sync_r[2] != wr_seen_r);

  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      wr_sync_r <= 3'h0;
      wr_seen_r <= 1'b0;
      cs_sync_r <= 3'h7;
      cs_high_r <= 1'b1;
    end
    else
    begin
      wr_sync_r <= {wr_sync_r[1:0], wr_tgl_r};
      cs_sync_r <= {cs_sync_r[1:0], cs_n};
      if (wr_evt)
        wr_seen_r <= wr_sync_r[2];
      if (cs_sync_r[1] == cs_sync_r[2])
        cs_high_r <= cs_sync_r[2];
    end
  end

  // ****************************************
  // system side: register bank
  // ****************************************
  logic [DATA_W-1:0] bank_r [1:4];
  logic swrst_r;
  logic swrst_hit;

  assign swrst_hit = wr_evt && wr_addr_r == ADDR_SW_RESET && wr_data_r[SWRST_BIT];

  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      for (int i = 1; i <= 4; i++)
        bank_r[i] <= REG_RESET;
    end
    else if (swrst_hit)
    begin
      for (int i = 1; i <= 4; i++)
        bank_r[i] <= REG_RESET; // [R1]
    end
    else if (wr_evt && mapped(wr_addr_r)) // [R26]
      bank_r[wr_addr_r[2:0]] <= wr_data_r & reg_mask(wr_addr_r[2:0]); // [R21]
  end

  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
      swrst_r <= 1'b0;
    else if (swrst_hit)
      swrst_r <= 1'b1;
    else if (cs_high_r)
      swrst_r <= 1'b0; // [R3]
  end

  // publish bank for readback
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      pub_r <= 32'h00000000;
      pub_tgl_r <= 1'b0;
    end
    else if (pub_r != {bank_r[4], bank_r[3], bank_r[2], bank_r[1]})
    begin
      pub_r <= {bank_r[4], bank_r[3], bank_r[2], bank_r[1]};
      pub_tgl_r <= !pub_tgl_r;
    end
  end

  // ****************************************
  // system side: decoded controls
  // ****************************************
  logic [1:0] pwr;
  logic [2:0] cur;
  logic [2:0] tp;

  assign pwr = swrst_r ? PWR_SLEEP : bank_r[1][PWR_LSB +: 2]; // [R2] [R5]
  assign cur = bank_r[3][CUR_LSB +: 3];
  assign tp = bank_r[4][TEST_LSB +: 3];

  // base current held in a net so that it can be part-selected
  logic [9:0] cur_base;

  assign cur_base = cur_of(cur);

  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      software_reset_active <= 1'b0;
      power_down_select <= PWR_NORMAL;
      channel1_napped <= 1'b0;
      channel2_napped <= 1'b0;
      full_sleep <= 1'b0;
      output_clock_invert <= 1'b0;
      output_clock_phase_delay <= 2'h0;
      duty_cycle_stabilizer_on <= 1'b0;
      differential_drive_current <= 3'h0;
      drive_current_10ua <= CUR_3P50;
      internal_termination_on <= 1'b0;
      output_disable <= 1'b0;
      output_format_select <= 2'h0;
    end
    else
    begin
      software_reset_active <= swrst_r;
      power_down_select <= pwr;
      channel1_napped <= pwr == PWR_NAP_BOTH; // [R5]
      channel2_napped <= pwr == PWR_NAP2 || pwr == PWR_NAP_BOTH;
      full_sleep <= pwr == PWR_SLEEP;
      output_clock_invert <= bank_r[2][OUTPUT_CLOCK_INVERT_BIT]; // [R6]
      output_clock_phase_delay <= bank_r[2][PHASE_LSB +: 2]; // [R7]
      duty_cycle_stabilizer_on <= bank_r[2][DCS_BIT]; // [R9]
      differential_drive_current <= cur; // [R10]
      if (bank_r[3][TERM_BIT])
        drive_current_10ua <= {cur_base[8:0], 1'b0}; // [R11]
      else
        drive_current_10ua <= cur_base; // [R10]
      internal_termination_on <= bank_r[3][TERM_BIT]; // [R11]
      output_disable <= bank_r[3][OFF_BIT]; // [R12]
      output_format_select <= bank_r[3][FMT_LSB +: 2]; // [R14]
    end
  end

  // ****************************************
  // system side: test patterns and format
  // ****************************************
  logic phase_r;
  logic tp_on;
  logic [14:0] tp_word;

  assign tp_on = tp == TP_LOW || tp == TP_HIGH || tp == TP_CHECKER || tp == TP_TOGGLE;

  always_comb
  begin
    tp_word = WORD_ZERO; // [R15]
    case (tp)
      TP_HIGH: tp_word = WORD_ONE; // [R15]
      TP_CHECKER: tp_word = phase_r ? CHECKER_B : CHECKER_A; // [R16]
      TP_TOGGLE: tp_word = phase_r ? WORD_ONE : WORD_ZERO; // [R17]
      default: tp_word = WORD_ZERO;
    endcase
  end

  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
      phase_r <= 1'b0;
    else if (!tp_on)
      phase_r <= 1'b0;
    else if (sample_tick)
      phase_r <= !phase_r;
  end

  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      test_pattern_select <= TP_OFF;
      test_pattern_active <= 1'b0;
      overflow_flag <= 1'b0;
      sample_bits <= 14'h0000;
      alternate_polarity_on <= 1'b0;
      output_scrambler_on <= 1'b0;
      signed_format_select <= 1'b0;
    end
    else
    begin
      test_pattern_select <= tp;
      test_pattern_active <= tp_on;
      overflow_flag <= tp_word[14];
      sample_bits <= tp_word[13:0];
      alternate_polarity_on <= !tp_on && bank_r[4][ABP_BIT]; // [R25] [R18]
      output_scrambler_on <= !tp_on && bank_r[4][OUTPUT_SCRAMBLER_ON_BIT]; // [R25] [R19]
      signed_format_select <= !tp_on && !bank_r[4][ABP_BIT]
        && bank_r[4][TWOS_BIT]; // [R18] [R20] [R25]
    end
  end

endmodule // adc_mode_control_registers

// file: src/adc_mode_pkg.sv
// constants for the converter mode control register bank
// What this block does
// R1: writing one to reset bit 7 at 00h clears every mode register
// R2: during a software reset the device is held in full sleep
// R3: the software reset bit clears itself when its write command ends
// R4: reset register is write-only; its readback value is arbitrary
// R5: power-down bits 1-0 of 01h pick normal, nap ch2, nap both, sleep
// R6: timing bit 3 inverts the forwarded sample clock
// R7: phase bits 2-1 delay the forwarded clock by 0, 1/8, 1/4, 3/8 period
// R8: host must enable the stabilizer whenever a phase delay is used
// R9: timing bit 0 turns the duty cycle stabilizer on or off
// R10: bits 6-4 of 03h pick drive current, from 1.75mA up to 4.5mA (3.5mA at code 000)
// R11: bit 3 of 03h enables termination and doubles drive current
// R12: bit 2 of 03h places all digital outputs in high impedance
// R13: host should nap or sleep both channels when outputs are off
// R14: bits 1-0 of 03h pick full-rate, double-rate differential or single-ended
// R15: bits 5-3 of 04h pick test pattern: off, all low, all high
// R16: pattern 101 alternates the two checkerboard words each sample
// R17: pattern 111 alternates all zeros and all ones each sample
// R18: format bit 2 turns on alternate polarity and forces offset binary
// R19: format bit 1 enables the output scrambler
// R20: format bit 0 selects two's complement, else offset binary
// R21: upper six bits of the power-down register are ignored
// R22: sixteen-bit word, msb first: read flag, seven address bits, data
// R23: sample input on first sixteen rising edges while select is low
// R24: read shifts register out on open-drain output, leaves it unchanged
// R25: an active test pattern overrides all other output formatting
// R26: unmapped writes change nothing; unmapped reads return an arbitrary value
package adc_mode_pkg;
  // ****************************************
  // serial word layout
  // ****************************************
  localparam int ADDR_W = 7;
  localparam int DATA_W = 8;
  localparam logic [4:0] WORD_BITS = 5'h10;
  localparam logic [4:0] ADDR_DONE = 5'h08;
  localparam logic [4:0] LAST_EDGE = 5'h0F;
  localparam logic [DATA_W-1:0] REG_RESET = 8'h00;
  // ****************************************
  // register offsets and masks
  // ****************************************
  localparam logic [ADDR_W-1:0] ADDR_SW_RESET = 7'h00;
  localparam logic [ADDR_W-1:0] ADDR_POWER = 7'h01;
  localparam logic [ADDR_W-1:0] ADDR_TIMING = 7'h02;
  localparam logic [ADDR_W-1:0] ADDR_DRIVER = 7'h03;
  localparam logic [ADDR_W-1:0] ADDR_FORMAT = 7'h04;
  localparam logic [DATA_W-1:0] MASK_POWER = 8'h03;
  localparam logic [DATA_W-1:0] MASK_TIMING = 8'h0F;
  localparam logic [DATA_W-1:0] MASK_DRIVER = 8'h7F;
  localparam logic [DATA_W-1:0] MASK_FORMAT = 8'h3F;
  // ****************************************
  // field positions
  // ****************************************
  localparam int SWRST_BIT = 7;
  localparam int PWR_LSB = 0;
  localparam int OUTPUT_CLOCK_INVERT_BIT = 3;
  localparam int PHASE_LSB = 1;
  localparam int DCS_BIT = 0;
  localparam int CUR_LSB = 4;
  localparam int TERM_BIT = 3;
  localparam int OFF_BIT = 2;
  localparam int FMT_LSB = 0;
  localparam int TEST_LSB = 3;
  localparam int ABP_BIT = 2;
  localparam int OUTPUT_SCRAMBLER_ON_BIT = 1;
  localparam int TWOS_BIT = 0;
  // ****************************************
  // codes
  // ****************************************
  localparam logic [1:0] PWR_NORMAL = 2'h0;
  localparam logic [1:0] PWR_NAP2 = 2'h1;
  localparam logic [1:0] PWR_NAP_BOTH = 2'h2;
  localparam logic [1:0] PWR_SLEEP = 2'h3;
  localparam logic [2:0] TP_OFF = 3'h0;
  localparam logic [2:0] TP_LOW = 3'h1;
  localparam logic [2:0] TP_HIGH = 3'h3;
  localparam logic [2:0] TP_CHECKER = 3'h5;
  localparam logic [2:0] TP_TOGGLE = 3'h7;
  localparam logic [14:0] WORD_ZERO = 15'h0000;
  localparam logic [14:0] WORD_ONE = 15'h7FFF;
  localparam logic [14:0] CHECKER_A = 15'h5555;
  localparam logic [14:0] CHECKER_B = 15'h2AAA;
  // drive current in units of 10 uA
  localparam logic [9:0] CUR_3P50 = 10'h15E;
  localparam logic [9:0] CUR_4P00 = 10'h190;
  localparam logic [9:0] CUR_4P50 = 10'h1C2;
  localparam logic [9:0] CUR_3P00 = 10'h12C;
  localparam logic [9:0] CUR_2P50 = 10'h0FA;
  localparam logic [9:0] CUR_2P10 = 10'h0D2;
  localparam logic [9:0] CUR_1P75 = 10'h0AF;
  localparam logic [9:0] CUR_UNUSED = 10'h000;
endpackage

// file: tb/adc_mode_checker.sv
// assertion checker for the mode control register bank
module adc_mode_checker (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic cs_n,
  input wire logic serial_data_out,
  input wire logic serial_data_out_oe,
  input wire logic software_reset_active,
  input wire logic [1:0] power_down_select,
  input wire logic channel1_napped,
  input wire logic channel2_napped,
  input wire logic full_sleep,
  input wire logic output_clock_invert,
  input wire logic [2:0] differential_drive_current,
  input wire logic [9:0] drive_current_10ua,
  input wire logic internal_termination_on,
  input wire logic [2:0] test_pattern_select,
  input wire logic test_pattern_active,
  input wire logic overflow_flag,
  input wire logic [13:0] sample_bits,
  input wire logic alternate_polarity_on,
  input wire logic output_scrambler_on,
  input wire logic signed_format_select
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [14:0] word;
  assign word = {overflow_flag, sample_bits};
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!resetn);
  sleep_in_reset_a:
    assert property (software_reset_active && $past(software_reset_active)
      |-> power_down_select == 2'h3) else $error("no sleep during software reset");
  sleep_decode_a:
    assert property ($stable(power_down_select) |-> full_sleep == (power_down_select == 2'h3))
      else $error("sleep decode wrong");
  nap_order_a:
    assert property (channel1_napped |-> channel2_napped) else $error("channel 1 napped alone");
  reset_clears_a:
    assert property ($fell(software_reset_active) |=> power_down_select == 2'h0
      && !output_clock_invert && differential_drive_current == 3'h0
      && test_pattern_select == 3'h0) else $error("software reset left a field set");
  reset_ends_a:
    assert property (software_reset_active && cs_n |-> ##[1:12] !software_reset_active)
      else $error("software reset did not clear itself");
  term_double_a:
    assert property (internal_termination_on && differential_drive_current == 3'h0
      && $stable(internal_termination_on) && $stable(differential_drive_current)
      |-> drive_current_10ua == 10'h2BC) else $error("current not doubled");
  pattern_wins_a:
    assert property (test_pattern_active && $past(test_pattern_active) |-> !alternate_polarity_on
      && !output_scrambler_on && !signed_format_select) else $error("format on under pattern");
  pattern_high_a:
    assert property (test_pattern_select == 3'h3 && $past(test_pattern_select) == 3'h3
      && test_pattern_active |-> word == 15'h7FFF) else $error("all ones pattern wrong");
  pattern_idle_a:
    assert property (!test_pattern_active && $past(test_pattern_active) == 1'b0
      |-> word == 15'h0000) else $error("pattern word without pattern");
  link_idle_a:
    assert property (cs_n && $past(cs_n) |-> !serial_data_out_oe && !serial_data_out)
      else $error("serial output driven outside frame");
endmodule // adc_mode_checker

// file: tb/host_link.sv
// host side of the serial configuration link
module host_link (
  output logic sck,
  output logic cs_n,
  output logic serial_data_in,
  input wire logic sdo_line,
  output logic rd_valid,
  output logic [7:0] rd_data
);
  timeunit 1ns;
  timeprecision 1ps;
  initial
  begin
    sck = 1'b0;
    cs_n = 1'b1;
    serial_data_in = 1'b0;
    rd_valid = 1'b0;
    rd_data = 8'h00;
  end
  // one frame msb first, clock still between frames
  task automatic xfer(input logic [15:0] w, input int n);
    int i;
    // offset keeps link edges clear of the system clock edges
    #13.7 cs_n = 1'b0;
    for (i = 0; i < n; i++)
    begin
      serial_data_in = (i < 16) ? w[15-i] : ~w[0];
      #40 sck = 1'b1;
      if (i >= 8 && i < 16)
        rd_data[15-i] = sdo_line;
      #40 sck = 1'b0;
    end
    #40 cs_n = 1'b1;
    serial_data_in = ~serial_data_in;
    rd_valid = w[15] && n == 16;
    #80 rd_valid = 1'b0;
  endtask
endmodule // host_link

// file: tb/adc_mode_control_registers_test.sv
// self-checking bench for the mode control register bank
module adc_mode_control_registers_test;
  import adc_mode_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys, resetn, sample_tick, sck, cs_n, serial_data_in, rd_valid;
  logic serial_data_out, serial_data_out_oe, software_reset_active, full_sleep;
  logic channel1_napped, channel2_napped, output_clock_invert, duty_cycle_stabilizer_on;
  logic internal_termination_on, output_disable, test_pattern_active, overflow_flag;
  logic alternate_polarity_on, output_scrambler_on, signed_format_select;
  logic [1:0] power_down_select, output_clock_phase_delay, output_format_select;
  logic [2:0] differential_drive_current, test_pattern_select;
  logic [9:0] drive_current_10ua;
  logic [13:0] sample_bits;
  logic [7:0] rd_data;
  logic [8:0] exp_q[$];
  logic [8:0] e;
  int n_errors = 0;
  int cmp_count = 0;
  wire logic sdo_line = serial_data_out_oe ? serial_data_out : 1'b1;
  adc_mode_control_registers u_dut (
    .clk_sys, .resetn, .sck, .cs_n, .serial_data_in, .serial_data_out, .serial_data_out_oe,
    .sample_tick, .software_reset_active, .power_down_select, .channel1_napped,
    .channel2_napped, .full_sleep, .output_clock_invert, .output_clock_phase_delay,
    .duty_cycle_stabilizer_on, .differential_drive_current, .drive_current_10ua,
    .internal_termination_on, .output_disable, .output_format_select, .test_pattern_select,
    .test_pattern_active, .overflow_flag, .sample_bits, .alternate_polarity_on,
    .output_scrambler_on, .signed_format_select
  );
  host_link u_host (.sck, .cs_n, .serial_data_in, .sdo_line, .rd_valid, .rd_data);
  // ****************************************
  // tasks
  // ****************************************
  task automatic cmp(input string what, input logic [15:0] x, input logic [15:0] g);
    cmp_count++;
    if (g !== x)
    begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", what, x, g);
    end
  endtask
  task automatic settle;
    repeat (4) @(posedge clk_sys);
    #1;
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    u_host.xfer({1'b0, a, d}, 16);
    settle();
  endtask
  task automatic rd(input logic [6:0] a, input logic [7:0] d, input logic skip);
    exp_q.push_back({skip, d});
    u_host.xfer({1'b1, a, 8'hA5}, 16);
  endtask
  task automatic tick;
    @(posedge clk_sys);
    sample_tick <= 1'b1;
    @(posedge clk_sys);
    sample_tick <= 1'b0;
    settle();
  endtask
  function automatic logic [9:0] cur(input logic [2:0] c, input logic t);
    logic [9:0] r;
    case (c)
      3'h0: r = CUR_3P50;
      3'h1: r = CUR_4P00;
      3'h2: r = CUR_4P50;
      3'h4: r = CUR_3P00;
      3'h5: r = CUR_2P50;
      3'h6: r = CUR_2P10;
      3'h7: r = CUR_1P75;
      default: r = CUR_UNUSED;
    endcase
    return t ? {r[8:0], 1'b0} : r;
  endfunction
  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // ****************************************
  // readback monitor and clock
  // ****************************************
  always @(posedge rd_valid)
  begin
    e = exp_q.pop_front();
    if (!e[8])
      cmp("readback", {8'h00, e[7:0]}, {8'h00, rd_data});
  end
  initial
  begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  initial
  begin
    #500us;
    n_errors++;
    wrap_up();
  end
  // ****************************************
  // tests
  // ****************************************
  initial
  begin
    logic [7:0] v;
    logic [7:0] d;
    logic [2:0] c;
    int k;
    resetn = 1'b0;
    sample_tick = 1'b0;
    void'($urandom(32'h0AB1));
    repeat (3) @(posedge clk_sys);
    resetn <= 1'b1;
    settle();
    cmp("drive", {6'h00, CUR_3P50}, {6'h00, drive_current_10ua});
    wr(ADDR_SW_RESET, 8'h80);
    $display("test reset done");
    for (k = 0; k < 4; k++)
    begin
      v = {6'($urandom), k[1:0]};
      wr(ADDR_POWER, v);
      cmp("power", {11'h000, (k == 2), (k == 1 || k == 2), (k == 3), k[1:0]},
        {11'h000, channel1_napped, channel2_napped, full_sleep, power_down_select});
      rd(ADDR_POWER, {6'h00, k[1:0]}, 1'b0);
    end
    $display("test power done");
    for (k = 0; k < 4; k++)
    begin
      v = {4'($urandom), 1'($urandom), k[1:0], (k != 0) | 1'($urandom)};
      wr(ADDR_TIMING, v);
      cmp("timing", {12'h000, v[3:0]}, {12'h000, output_clock_invert, output_clock_phase_delay,
        duty_cycle_stabilizer_on});
      rd(ADDR_TIMING, v & MASK_TIMING, 1'b0);
    end
    $display("test timing done");
    wr(ADDR_POWER, {6'h00, PWR_SLEEP});
    for (k = 0; k < 8; k++)
    begin
      d = {1'($urandom), k[2:0], (k == 0) | 1'($urandom), 3'($urandom)};
      wr(ADDR_DRIVER, d);
      cmp("current", {6'h00, cur(k[2:0], d[3])}, {6'h00, drive_current_10ua});
      cmp("driver", {12'h000, d[3:0]}, {12'h000, internal_termination_on, output_disable,
        output_format_select});
      rd(ADDR_DRIVER, d & MASK_DRIVER, 1'b0);
    end
    $display("test driver done");
    for (k = 0; k < 4; k++)
    begin
      c = 3'(2 * k + 1);
      wr(ADDR_FORMAT, {2'($urandom), c, 3'($urandom)});
      cmp("format", 16'h0008, {12'h000, test_pattern_active, alternate_polarity_on,
        output_scrambler_on, signed_format_select});
      cmp("word", {1'b0, c == 3 ? 15'h7FFF : c == 5 ? 15'h5555 : 15'h0000},
        {1'b0, overflow_flag, sample_bits});
      tick();
      cmp("word", {1'b0, c == 1 ? 15'h0000 : c == 5 ? 15'h2AAA : 15'h7FFF},
        {1'b0, overflow_flag, sample_bits});
      v = {2'($urandom), TP_OFF, (k == 0) ? 3'h5 : 3'($urandom)};
      wr(ADDR_FORMAT, v);
      cmp("format", {13'h0000, v[2:1], v[0] & ~v[2]}, {12'h000, test_pattern_active,
        alternate_polarity_on, output_scrambler_on, signed_format_select});
      rd(ADDR_FORMAT, v & MASK_FORMAT, 1'b0);
    end
    $display("test format done");
    wr(7'h0B, 8'h00);
    wr(7'h7C, 8'hFF);
    rd(ADDR_DRIVER, d & MASK_DRIVER, 1'b0);
    rd(ADDR_FORMAT, v & MASK_FORMAT, 1'b0);
    rd(7'h05, 8'h00, 1'b1);
    rd(ADDR_SW_RESET, 8'h00, 1'b1);
    u_host.xfer({1'b0, ADDR_POWER, 8'h00}, 8);
    settle();
    cmp("short frame", {14'h0000, PWR_SLEEP}, {14'h0000, power_down_select});
    u_host.xfer({1'b0, ADDR_POWER, 8'h01}, 20);
    settle();
    cmp("long frame", {14'h0000, PWR_NAP2}, {14'h0000, power_down_select});
    $display("test framing done");
    wr(ADDR_SW_RESET, 8'h80);
    cmp("cleared", 16'h0000, {2'h0, software_reset_active, power_down_select, output_clock_invert,
      output_clock_phase_delay, differential_drive_current, test_pattern_select,
      output_format_select});
    for (k = 1; k < 5; k++)
      rd(7'(k), 8'h00, 1'b0);
    $display("test software reset done");
    wrap_up();
  end
endmodule // adc_mode_control_registers_test
bind adc_mode_control_registers adc_mode_checker u_chk (
  .clk_sys, .resetn, .cs_n, .serial_data_out, .serial_data_out_oe, .software_reset_active,
  .power_down_select, .channel1_napped, .channel2_napped, .full_sleep, .output_clock_invert,
  .differential_drive_current, .drive_current_10ua, .internal_termination_on,
  .test_pattern_select, .test_pattern_active, .overflow_flag, .sample_bits,
  .alternate_polarity_on, .output_scrambler_on, .signed_format_select
);
